/* design/gdi_pkg.sv */
package gdi_pkg;

	// Clock and the settle time before settings are saved
	localparam longint CLK_HZ = 250_000_000;
	localparam longint STABLE_TIME_S = 15;
	localparam logic [31:0] STABLE_CYCLES = 32'(STABLE_TIME_S * CLK_HZ);

	// Register map, word index on the plain port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_CFG = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_EVENT = 4'h3;
	localparam logic [3:0] REG_SPOLL = 4'h4;

	// REG_CTRL write bits (commands, self clearing)
	localparam int CTL_ADDR_BEGIN = 0;
	localparam int CTL_ADDR_END = 1;
	localparam int CTL_ADDR_UP = 2;
	localparam int CTL_ADDR_DOWN = 3;
	localparam int CTL_TERM_BEGIN = 4;
	localparam int CTL_TERM_END = 5;
	// REG_CFG bits (staged terminator and mode)
	localparam int CFG_TERM_LF = 0;
	localparam int CFG_LISTEN_ONLY = 1;
	// REG_EVENT write bits
	localparam int EVT_ERROR = 0;
	localparam int EVT_WARNING = 1;
	localparam int EVT_CLR_LIMIT = 2;

	// Bus command bytes and address groups
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3f;
	localparam logic [6:0] CMD_UNT = 7'h5f;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK = 2'h2;
	localparam logic [4:0] ADDR_MAX = 5'h1f;
	localparam logic [4:0] ADDR_MIN = 5'h00;
	localparam logic [4:0] ADDR_DEFAULT = 5'h01;
	localparam logic [7:0] CHAR_CR = 8'h0d;
	localparam logic [7:0] CHAR_LF = 8'h0a;
	localparam logic [5:0] SB_POWER_ON = 6'h01;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} gdi_msg_type;

	typedef struct packed {
		logic [7:0] data;
		logic eoi;
	} gdi_bus_byte_type;

	typedef struct packed {
		logic valid;
		logic [4:0] addr;
		logic term_lf;
		logic listen_only;
	} gdi_nv_cfg_type;

	typedef enum logic [1:0] {TX_DATA, TX_CR, TX_LF} gdi_tx_phase_type;
	typedef enum logic [1:0] {RT_IDLE, RT_ADDR, RT_TERM} gdi_routine_type;

	typedef struct packed {
		logic booted;
		logic normal_mode;
		logic remote;
		logic lockout;
		logic listen_act;
		logic talk_act;
		logic spoll_mode;
		logic srq;
		logic limit;
		logic rtl;
		logic [4:0] addr;
		logic term_lf;
		logic listen_only;
		logic [4:0] edit_addr;
		logic edit_term_lf;
		logic edit_listen_only;
		gdi_routine_type routine;
		logic [5:0] sb_low;
		gdi_tx_phase_type tx_phase;
		gdi_bus_byte_type out;
		logic out_valid;
		logic out_is_poll;
		gdi_msg_type rx;
		logic rx_valid;
		gdi_nv_cfg_type nv_cfg;
		logic nv_cfg_wr;
		logic [15:0] func_last;
		logic [31:0] stable_cnt;
		logic func_saved;
		logic nv_func_wr;
		logic [15:0] func_restore;
		logic [15:0] rdata;
	} gdi_state_type;

endpackage

/* design/gdi_core.sv */
`timescale 1ns/1ps
module gdi_core
	import gdi_pkg::*;
#(
	parameter logic [31:0] P_STABLE_CYCLES = STABLE_CYCLES
)
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// Register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [15:0] o_reg_rdata,
	// Bus side, decoded by the transceiver
	input wire logic i_ren,
	input wire logic i_atn,
	input wire logic i_gpib_rx_valid,
	input wire gdi_bus_byte_type i_gpib_rx,
	output logic o_gpib_tx_valid,
	output gdi_bus_byte_type o_gpib_tx,
	input wire logic i_gpib_tx_ready,
	output logic o_srq_line,
	// Instrument message side
	input wire logic i_msg_tx_valid,
	input wire gdi_msg_type i_msg_tx,
	output logic o_msg_tx_ready,
	output logic o_msg_rx_valid,
	output gdi_msg_type o_msg_rx,
	// Front panel and indicators
	input wire logic i_panel_change,
	output logic o_panel_lock,
	output logic o_lock_ind,
	output logic o_srq_ind,
	output logic o_remote_state_indicator,
	output logic o_rtl,
	// Power-up, power-fail and settings store
	input wire logic i_selftest_ok,
	input wire logic i_power_fail,
	input wire gdi_nv_cfg_type i_nv_cfg,
	input wire logic [15:0] i_nv_func,
	input wire logic [15:0] i_panel_func,
	input wire logic [15:0] i_panel_mask,
	input wire logic [15:0] i_func,
	output logic o_normal_mode,
	output logic [15:0] o_func_restore,
	output gdi_nv_cfg_type o_nv_cfg,
	output logic o_nv_cfg_wr,
	output logic [15:0] o_nv_func,
	output logic o_nv_func_wr
);

	gdi_state_type st;
	gdi_state_type next_st;

	// Command decode helpers
	logic [6:0] cmd;
	logic cmd_strobe;
	logic addr_on;
	logic talk_en;
	logic evt_req;
	logic out_take;
	logic msg_take;

	// Address 31 parks the interface: no command is decoded at all
	assign cmd = i_gpib_rx.data[6:0];
	assign cmd_strobe = i_gpib_rx_valid && i_atn;
	assign addr_on = (st.addr != ADDR_MAX);
	assign talk_en = st.talk_act && !st.listen_only && addr_on && !i_atn;
	assign evt_req = i_reg_wr && (i_reg_addr == REG_EVENT)
		&& (i_reg_wdata[EVT_ERROR] || i_reg_wdata[EVT_WARNING]);

	// Handshakes are combinational; the byte itself is registered
	assign o_gpib_tx_valid = st.out_valid && talk_en;
	assign out_take = o_gpib_tx_valid && i_gpib_tx_ready;
	assign msg_take = i_msg_tx_valid && o_msg_tx_ready;
	// A user byte is taken only when the slot is free and no CR/LF tail is pending
	assign o_msg_tx_ready = st.booted && !st.out_valid && (st.tx_phase == TX_DATA)
		&& !st.spoll_mode && talk_en;

	always_comb
	begin
		next_st = st;
		next_st.rtl = 1'b0;
		next_st.nv_cfg_wr = 1'b0;
		next_st.nv_func_wr = 1'b0;
		next_st.rx_valid = 1'b0;
		next_st.rdata = '0;

		// First cycle after reset: restore settings and report power-on
		if (!st.booted)
		begin
			next_st.booted = 1'b1;
			next_st.normal_mode = i_selftest_ok;
			next_st.remote = 1'b0;
			next_st.srq = !i_power_fail;
			next_st.sb_low = SB_POWER_ON;
			if (i_nv_cfg.valid)
			begin
				next_st.addr = i_nv_cfg.addr;
				next_st.term_lf = i_nv_cfg.term_lf;
				next_st.listen_only = i_nv_cfg.listen_only;
			end
			next_st.edit_addr = next_st.addr;
			next_st.edit_term_lf = next_st.term_lf;
			next_st.edit_listen_only = next_st.listen_only;
			// Live panel switches override the stored values bit by bit
			next_st.func_restore = (i_panel_func & i_panel_mask)
				| (i_nv_func & ~i_panel_mask);
			next_st.func_last = i_func;
		end
		else
		begin
			// Bus commands, primary addresses only
			if (cmd_strobe && addr_on)
			begin
				if (cmd == CMD_LLO && i_ren)
				begin
					next_st.lockout = 1'b1;
				end
				if (cmd == CMD_GTL && st.listen_act)
				begin
					next_st.remote = 1'b0;
				end
				if (cmd == CMD_SPE)
				begin
					next_st.spoll_mode = 1'b1;
				end
				if (cmd == CMD_SPD)
				begin
					next_st.spoll_mode = 1'b0;
				end
				if (cmd == CMD_UNL)
				begin
					next_st.listen_act = 1'b0;
				end
				else if (cmd[6:5] == GRP_LISTEN && cmd[4:0] == st.addr)
				begin
					next_st.listen_act = 1'b1;
					if (i_ren)
					begin
						next_st.remote = 1'b1;
					end
				end
				if (cmd == CMD_UNT)
				begin
					next_st.talk_act = 1'b0;
				end
				else if (cmd[6:5] == GRP_TALK)
				begin
					// Another talker's address untalks this one
					next_st.talk_act = (cmd[4:0] == st.addr);
				end
			end

			// Dropping remote enable returns everything to local
			if (!i_ren)
			begin
				next_st.remote = 1'b0;
				next_st.lockout = 1'b0;
			end

			// Panel activity always signals return-to-local
			if (i_panel_change)
			begin
				next_st.rtl = 1'b1;
				if (!st.lockout)
				begin
					next_st.remote = 1'b0;
				end
			end

			// Incoming data bytes when addressed to listen
			if (i_gpib_rx_valid && !i_atn && st.listen_act && addr_on)
			begin
				next_st.rx_valid = 1'b1;
				next_st.rx.data = i_gpib_rx.data;
				if (st.term_lf)
				begin
					next_st.rx.last = i_gpib_rx.eoi || (i_gpib_rx.data == CHAR_LF);
				end
				else
				begin
					next_st.rx.last = i_gpib_rx.eoi;
				end
			end

			// Output byte slot: a taken byte frees it
			if (out_take)
			begin
				next_st.out_valid = 1'b0;
				if (st.out_is_poll)
				begin
					next_st.srq = 1'b0;
				end
			end
			if (!st.out_valid && talk_en)
			begin
				if (st.spoll_mode)
				begin
					next_st.out.data = {1'b0, st.srq, st.sb_low};
					next_st.out.eoi = 1'b0;
					next_st.out_valid = 1'b1;
					next_st.out_is_poll = 1'b1;
				end
				else
				begin
					next_st.out_is_poll = 1'b0;
					case (st.tx_phase)
						TX_DATA:
						begin
							if (msg_take)
							begin
								next_st.out.data = i_msg_tx.data;
								next_st.out.eoi = i_msg_tx.last && !st.term_lf;
								next_st.out_valid = 1'b1;
								if (i_msg_tx.last && st.term_lf)
								begin
									next_st.tx_phase = TX_CR;
								end
							end
						end
						TX_CR:
						begin
							next_st.out.data = CHAR_CR;
							next_st.out.eoi = 1'b0;
							next_st.out_valid = 1'b1;
							next_st.tx_phase = TX_LF;
						end
						TX_LF:
						begin
							next_st.out.data = CHAR_LF;
							next_st.out.eoi = 1'b1;
							next_st.out_valid = 1'b1;
							next_st.tx_phase = TX_DATA;
						end
						default:
						begin
							next_st.tx_phase = TX_DATA;
						end
					endcase
				end
			end

			// Software writes
			if (i_reg_wr)
			begin
				case (i_reg_addr)
					REG_CTRL:
					begin
						case (st.routine)
							RT_IDLE:
							begin
								if (i_reg_wdata[CTL_ADDR_BEGIN])
								begin
									next_st.routine = RT_ADDR;
									next_st.edit_addr = st.addr;
								end
								else if (i_reg_wdata[CTL_TERM_BEGIN])
								begin
									next_st.routine = RT_TERM;
									next_st.edit_term_lf = st.term_lf;
									next_st.edit_listen_only = st.listen_only;
								end
							end
							RT_ADDR:
							begin
								// Stepping past either end keeps the value
								if (i_reg_wdata[CTL_ADDR_UP])
								begin
									if (st.edit_addr == ADDR_MAX)
									begin
										next_st.limit = 1'b1;
									end
									else
									begin
										next_st.edit_addr = st.edit_addr + 5'h01;
									end
								end
								else if (i_reg_wdata[CTL_ADDR_DOWN])
								begin
									if (st.edit_addr == ADDR_MIN)
									begin
										next_st.limit = 1'b1;
									end
									else
									begin
										next_st.edit_addr = st.edit_addr - 5'h01;
									end
								end
								if (i_reg_wdata[CTL_ADDR_END])
								begin
									next_st.routine = RT_IDLE;
									next_st.addr = next_st.edit_addr;
									next_st.nv_cfg_wr = 1'b1;
									// A new address drops the old addressing
									next_st.listen_act = 1'b0;
									next_st.talk_act = 1'b0;
								end
							end
							RT_TERM:
							begin
								if (i_reg_wdata[CTL_TERM_END])
								begin
									next_st.routine = RT_IDLE;
									next_st.term_lf = st.edit_term_lf;
									next_st.listen_only = st.edit_listen_only;
									next_st.nv_cfg_wr = 1'b1;
								end
							end
							default:
							begin
								next_st.routine = RT_IDLE;
							end
						endcase
					end
					REG_CFG:
					begin
						// Staged only; takes effect when the routine ends
						if (st.routine == RT_TERM)
						begin
							next_st.edit_term_lf = i_reg_wdata[CFG_TERM_LF];
							next_st.edit_listen_only = i_reg_wdata[CFG_LISTEN_ONLY];
						end
					end
					REG_EVENT:
					begin
						if (i_reg_wdata[EVT_CLR_LIMIT])
						begin
							next_st.limit = 1'b0;
						end
					end
					REG_SPOLL:
					begin
						next_st.sb_low = i_reg_wdata[5:0];
					end
					default:
					begin
					end
				endcase
			end

			// Set wins over the serial-poll clear in the same cycle
			if (evt_req && !i_power_fail)
			begin
				next_st.srq = 1'b1;
			end
			if (i_power_fail)
			begin
				next_st.srq = 1'b0;
			end

			// Save the functions once they held still for the settle time
			if (i_func != st.func_last)
			begin
				next_st.func_last = i_func;
				next_st.stable_cnt = '0;
				next_st.func_saved = 1'b0;
			end
			else if (!st.func_saved)
			begin
				if (st.stable_cnt >= P_STABLE_CYCLES - 32'h1)
				begin
					next_st.nv_func_wr = 1'b1;
					next_st.func_saved = 1'b1;
				end
				else
				begin
					next_st.stable_cnt = st.stable_cnt + 32'h1;
				end
			end
		end

		next_st.nv_cfg.valid = 1'b1;
		next_st.nv_cfg.addr = next_st.addr;
		next_st.nv_cfg.term_lf = next_st.term_lf;
		next_st.nv_cfg.listen_only = next_st.listen_only;

		// Read data appear the cycle after the strobe only
		if (i_reg_rd)
		begin
			case (i_reg_addr)
				REG_CTRL:
					next_st.rdata = {14'h0000, (st.routine == RT_TERM), (st.routine == RT_ADDR)};
				REG_CFG:
					next_st.rdata = {9'h000, st.edit_addr, st.edit_listen_only, st.edit_term_lf};
				REG_STATUS:
					next_st.rdata = {st.normal_mode, st.limit, st.remote, st.lockout, st.srq,
						st.listen_only, st.term_lf, st.talk_act, st.listen_act,
						st.spoll_mode, 1'b0, st.addr};
				REG_SPOLL:
					next_st.rdata = {9'h000, st.srq, st.sb_low};
				default:
					next_st.rdata = '0;
			endcase
		end
	end

	// State register; address and mode fall back to their defaults
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st <= '0;
			st.addr <= ADDR_DEFAULT;
			st.listen_only <= 1'b0;
			st.sb_low <= SB_POWER_ON;
			st.routine <= RT_IDLE;
			st.tx_phase <= TX_DATA;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Outputs straight from the state, except that the SRQ line is also masked by addr_on and i_power_fail
	assign o_reg_rdata = st.rdata;
	assign o_gpib_tx = st.out;
	assign o_srq_line = st.srq && addr_on && !i_power_fail;
	assign o_srq_ind = st.srq;
	assign o_lock_ind = st.lockout;
	assign o_panel_lock = st.remote && st.lockout;
	assign o_remote_state_indicator = st.remote;
	assign o_rtl = st.rtl;
	assign o_msg_rx_valid = st.rx_valid;
	assign o_msg_rx = st.rx;
	assign o_normal_mode = st.normal_mode;
	assign o_func_restore = st.func_restore;
	assign o_nv_cfg = st.nv_cfg;
	assign o_nv_cfg_wr = st.nv_cfg_wr;
	assign o_nv_func = st.func_last;
	assign o_nv_func_wr = st.nv_func_wr;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);

	a_lock_set: assert property (st.booted && cmd_strobe && cmd == CMD_LLO && i_ren && addr_on
		|=> o_lock_ind) else $error("lockout not lit after LLO");
	a_panel_held: assert property (st.booted && i_ren && o_panel_lock && i_panel_change
		|=> o_remote_state_indicator && o_panel_lock) else $error("locked panel left remote");
	a_srq_event: assert property (st.booted && evt_req && !i_power_fail
		|=> o_srq_ind ##0 o_srq_line == addr_on) else $error("event gave no SRQ");
	a_remote_cause: assert property ($rose(st.remote)
		|-> $past(i_ren) && $past(cmd_strobe)) else $error("remote without request");
	a_remote_drop: assert property (st.booted && st.remote && !st.lockout && i_panel_change
		|=> !o_remote_state_indicator && o_rtl) else $error("panel did not leave remote");
	a_boot_status: assert property ($rose(st.booted) && !$past(i_power_fail)
		|-> st.srq && !st.remote && {1'b0, st.srq, st.sb_low} == 8'h41)
		else $error("power-up status wrong");
	a_power_off: assert property (i_power_fail |-> !o_srq_line ##1 !o_srq_ind)
		else $error("SRQ during power off");
	a_addr_clamp: assert property (st.routine == RT_ADDR && st.edit_addr == ADDR_MAX && i_reg_wr
		&& i_reg_addr == REG_CTRL && i_reg_wdata[CTL_ADDR_UP]
		|=> st.edit_addr == ADDR_MAX && st.limit) else $error("address passed 31");
	a_lf_tail: assert property (o_gpib_tx_valid && o_gpib_tx.eoi && st.term_lf && !st.out_is_poll
		|-> o_gpib_tx.data == CHAR_LF) else $error("EOI not on LF");
	a_listen_quiet: assert property (st.listen_only |-> !o_gpib_tx_valid && !o_msg_tx_ready)
		else $error("talked in listen-only");
	a_poll_clear: assert property (out_take && st.out_is_poll && !evt_req
		|=> !o_srq_ind) else $error("SRQ kept after poll");

endmodule

/* tb/gdi_ctl_model.sv */
`timescale 1ns/1ps
module gdi_ctl_model
	import gdi_pkg::*;
(
	// Clock
	input wire logic i_sys_clk,
	// Controller drive
	output logic o_ren,
	output logic o_atn,
	output logic o_rx_valid,
	output gdi_bus_byte_type o_rx,
	output logic o_tx_ready,
	// Device talk
	input wire logic i_tx_valid,
	input wire gdi_bus_byte_type i_tx
);
	logic slow;
	gdi_bus_byte_type got[$];

	// Lines idle at time zero
	initial
	begin
		slow = 1'b0;
		o_ren = 1'b0;
		o_atn = 1'b0;
		o_rx_valid = 1'b0;
		o_rx = '0;
	end

	// Remote enable is the controller's own request
	task automatic set_ren(input logic v);
		@(posedge i_sys_clk);
		o_ren <= v;
	endtask

	// One byte per call; released data shows the inverse so stale bytes never match
	task automatic put(input logic atn, input logic [7:0] d, input logic eoi);
		@(posedge i_sys_clk);
		o_atn <= atn;
		o_rx_valid <= 1'b1;
		o_rx <= '{data: d, eoi: eoi};
		@(posedge i_sys_clk);
		o_atn <= 1'b0;
		o_rx_valid <= 1'b0;
		o_rx <= '{data: ~d, eoi: ~eoi};
	endtask

	// Accept talked bytes; slow mode stalls every other cycle
	always @(posedge i_sys_clk)
	begin
		if (i_tx_valid && o_tx_ready)
			got.push_back(i_tx);
		o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
	end
	initial o_tx_ready = 1'b1;
endmodule

/* tb/tb_gpib_device_interface_config.sv */
`timescale 1ns/1ps
module tb_gpib_device_interface_config
	import gdi_pkg::*;
;
	logic clk, nrst, wr, rd, ren, atn, rxv, txv, txr, srql, msgv, mrdy, mrxv;
	logic pchg, plock, lind, sind, remi, rtl, ok, pfail, nmode, nvcw, nvfw;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, nvf, pf, pm, fn, frest, nvfo;
	gdi_bus_byte_type rx, tx;
	gdi_msg_type msg, mrx;
	gdi_nv_cfg_type nvcfg, nvc, nvl;
	gdi_msg_type rxq[$];
	int err_count, total_checks, nvw;

	gdi_core #(.P_STABLE_CYCLES(32'd20)) dut (.i_sys_clk(clk), .i_nrst(nrst),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .i_ren(ren), .i_atn(atn), .i_gpib_rx_valid(rxv),
		.i_gpib_rx(rx), .o_gpib_tx_valid(txv), .o_gpib_tx(tx), .i_gpib_tx_ready(txr),
		.o_srq_line(srql), .i_msg_tx_valid(msgv), .i_msg_tx(msg), .o_msg_tx_ready(mrdy),
		.o_msg_rx_valid(mrxv), .o_msg_rx(mrx), .i_panel_change(pchg), .o_panel_lock(plock),
		.o_lock_ind(lind), .o_srq_ind(sind), .o_remote_state_indicator(remi), .o_rtl(rtl),
		.i_selftest_ok(ok), .i_power_fail(pfail), .i_nv_cfg(nvcfg), .i_nv_func(nvf),
		.i_panel_func(pf), .i_panel_mask(pm), .i_func(fn), .o_normal_mode(nmode),
		.o_func_restore(frest), .o_nv_cfg(nvc), .o_nv_cfg_wr(nvcw), .o_nv_func(nvfo),
		.o_nv_func_wr(nvfw));

	gdi_ctl_model m (.i_sys_clk(clk), .o_ren(ren), .o_atn(atn), .o_rx_valid(rxv),
		.o_rx(rx), .o_tx_ready(txr), .i_tx_valid(txv), .i_tx(tx));

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Store writes and received bytes, sampled before the edge's updates land
	always @(posedge clk)
	begin
		if (nvcw)
		begin
			nvw++;
			nvl = nvc;
		end
		if (mrxv)
			rxq.push_back(mrx);
	end

	task chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task print_verdict;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task settle;
		@(posedge clk);
		#1;
	endtask

	// One-cycle panel change on the edge; returns while the rtl pulse stands
	task poke_panel;
		@(posedge clk);
		pchg <= 1'b1;
		@(posedge clk);
		pchg <= 1'b0;
		#1;
	endtask

	task wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task rchk(input logic [3:0] a, input logic [15:0] mk, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata & mk, e);
	endtask

	task send_msg(input logic [7:0] b, input logic l);
		int n;
		logic r;
		@(posedge clk);
		msgv <= 1'b1;
		msg <= '{data: b, last: l};
		n = 0;
		do
		begin
			#1 r = mrdy;
			@(posedge clk);
			n++;
		end while (!r && n < 50);
		msgv <= 1'b0;
	endtask

	task wait_tx(input int cnt);
		for (int i = 0; i < 100 && m.got.size() < cnt; i++)
			@(posedge clk);
	endtask

	task do_reset;
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
	endtask

	task term_cfg(input logic [15:0] v);
		wreg(REG_CTRL, 16'h1 << CTL_TERM_BEGIN);
		wreg(REG_CFG, v);
		wreg(REG_CTRL, 16'h1 << CTL_TERM_END);
		settle;
	endtask

	// Serial poll at address 1, status byte then withdrawal
	task t_poll;
		m.got.delete();
		m.put(1'b1, {1'b0, CMD_SPE}, 1'b0);
		m.put(1'b1, {1'b0, GRP_TALK, 5'h01}, 1'b0);
		wait_tx(1);
		chk(16'(m.got[0].data), 16'h0041);
		repeat (2) settle;
		chk(16'(srql), 16'h0);
		rchk(REG_SPOLL, 16'h0040, 16'h0);
		m.put(1'b1, {1'b0, CMD_SPD}, 1'b0);
		m.put(1'b1, {1'b0, CMD_UNT}, 1'b0);
	endtask

	task t_boot;
		rchk(REG_STATUS, 16'hffdf, 16'h8801);
		rchk(REG_SPOLL, 16'h007f, 16'h0041);
		chk(16'(srql), 16'h1);
		chk(frest, (nvf & ~pm) | (pf & pm));
		for (int n = 0; n < 60 && nvfw !== 1'b1; n++)
			settle;
		chk(16'(nvfw), 16'h1);
		chk(nvfo, fn);
		t_poll;
	endtask

	// Power fail clears the request, so a fresh warning is raised before the poll
	task t_srq;
		wreg(REG_EVENT, 16'h1 << EVT_WARNING);
		settle;
		chk(16'({srql, sind}), 16'h3);
		@(posedge clk);
		pfail <= 1'b1;
		settle;
		chk(16'({srql, sind}), 16'h0);
		@(posedge clk);
		pfail <= 1'b0;
		wreg(REG_EVENT, 16'h1 << EVT_WARNING);
		t_poll;
		wreg(REG_EVENT, 16'h1 << EVT_ERROR);
		settle;
		chk(16'({srql, sind}), 16'h3);
		t_poll;
	endtask

	task t_lock;
		m.set_ren(1'b1);
		m.put(1'b1, {1'b0, GRP_LISTEN, 5'h01}, 1'b0);
		m.put(1'b1, {1'b0, CMD_LLO}, 1'b0);
		#1;
		chk(16'(lind), 16'h1);
		chk(16'(remi), 16'h1);
		chk(16'(plock), 16'h1);
		poke_panel;
		chk(16'({rtl, remi}), 16'h3);
		m.set_ren(1'b0);
		repeat (2) settle;
		chk(16'({lind, remi, plock}), 16'h0);
		m.set_ren(1'b1);
		m.put(1'b1, {1'b0, GRP_LISTEN, 5'h01}, 1'b0);
		#1;
		chk(16'({remi, plock}), 16'h2);
		poke_panel;
		chk(16'({rtl, remi}), 16'h2);
		m.put(1'b1, {1'b0, GRP_LISTEN, 5'h01}, 1'b0);
		m.put(1'b1, {1'b0, CMD_GTL}, 1'b0);
		#1;
		chk(16'(remi), 16'h0);
		m.set_ren(1'b0);
	endtask

	// Address edit clamps at zero and stores only at the end
	task t_addr;
		wreg(REG_CTRL, 16'h1 << CTL_ADDR_BEGIN);
		wreg(REG_CTRL, 16'h1 << CTL_ADDR_DOWN);
		wreg(REG_CTRL, 16'h1 << CTL_ADDR_DOWN);
		rchk(REG_CFG, 16'h007c, 16'h0);
		rchk(REG_STATUS, 16'h401f, 16'h4001);
		chk(16'(nvw), 16'h0);
		wreg(REG_CTRL, 16'h1 << CTL_ADDR_END);
		settle;
		chk(16'(nvw), 16'h1);
		chk(16'(nvl.addr), 16'h0);
		wreg(REG_EVENT, 16'h1 << EVT_CLR_LIMIT);
		m.put(1'b1, {1'b0, GRP_LISTEN, 5'h00}, 1'b0);
		rchk(REG_STATUS, 16'h409f, 16'h0080);
	endtask

	task t_lf;
		gdi_bus_byte_type e[3];
		term_cfg(16'h1 << CFG_TERM_LF);
		chk(16'({nvl.term_lf, nvl.listen_only}), 16'h2);
		rxq.delete();
		m.put(1'b0, 8'h41, 1'b0);
		m.put(1'b0, CHAR_LF, 1'b0);
		m.put(1'b0, 8'h42, 1'b1);
		settle;
		chk(16'({rxq[0].last, rxq[1].last, rxq[2].last}), 16'h3);
		m.got.delete();
		m.put(1'b1, {1'b0, GRP_TALK, 5'h00}, 1'b0);
		send_msg(8'h58, 1'b1);
		wait_tx(3);
		e = '{'{8'h58, 1'b0}, '{CHAR_CR, 1'b0}, '{CHAR_LF, 1'b1}};
		for (int i = 0; i < 3; i++)
			chk(16'(m.got[i]), 16'(e[i]));
	endtask

	task t_eoi;
		term_cfg(16'h0);
		m.put(1'b1, {1'b0, GRP_LISTEN, 5'h00}, 1'b0);
		rxq.delete();
		m.put(1'b0, CHAR_LF, 1'b0);
		m.put(1'b0, 8'h43, 1'b1);
		settle;
		chk(16'({rxq[0].last, rxq[1].last}), 16'h1);
		m.slow = 1'b1;
		m.got.delete();
		m.put(1'b1, {1'b0, GRP_TALK, 5'h00}, 1'b0);
		send_msg(8'h59, 1'b1);
		wait_tx(1);
		repeat (10) settle;
		chk(16'(m.got.size()), 16'h1);
		chk(16'(m.got[0]), {7'h0, 8'h59, 1'b1});
		m.slow = 1'b0;
	endtask

	task t_lonly;
		term_cfg(16'h1 << CFG_LISTEN_ONLY);
		rchk(REG_STATUS, 16'h0600, 16'h0400);
		m.got.delete();
		m.put(1'b1, {1'b0, GRP_TALK, 5'h00}, 1'b0);
		send_msg(8'h5a, 1'b1);
		repeat (20) settle;
		chk(16'(m.got.size()), 16'h0);
		m.put(1'b1, {1'b0, GRP_LISTEN, 5'h00}, 1'b0);
		rxq.delete();
		m.put(1'b0, 8'h44, 1'b1);
		settle;
		chk(16'(rxq.size()), 16'h1);
	endtask

	// Failed self-test at the parked address: power-on status, quiet bus, upper clamp
	task t_fail;
		@(posedge clk);
		ok <= 1'b0;
		nvcfg <= '{valid: 1'b1, addr: ADDR_MAX, term_lf: 1'b0, listen_only: 1'b0};
		do_reset;
		m.put(1'b1, {1'b0, CMD_SPE}, 1'b0);
		rchk(REG_STATUS, 16'ha840, 16'h0800);
		rchk(REG_SPOLL, 16'h007f, 16'h0041);
		chk(16'({sind, srql, remi, nmode}), 16'h8);
		wreg(REG_CTRL, 16'h1 << CTL_ADDR_BEGIN);
		wreg(REG_CTRL, 16'h1 << CTL_ADDR_UP);
		rchk(REG_STATUS, 16'h401f, 16'h401f);
	endtask

	// Main sequence
	initial
	begin
		{nrst, wr, rd, msgv, pchg, pfail} = '0;
		ok = 1'b1;
		addr = '0;
		wdata = '0;
		msg = '0;
		nvcfg = '0;
		nvf = 16'h1234;
		pf = 16'habcd;
		pm = 16'h00f0;
		fn = 16'h5a5a;
		err_count = 0;
		total_checks = 0;
		nvw = 0;
		do_reset;
		t_boot;
		t_srq;
		t_lock;
		t_addr;
		t_lf;
		t_eoi;
		t_lonly;
		t_fail;
		print_verdict;
	end

	// Watchdog well beyond the expected run
	initial
	begin
		#100000;
		err_count++;
		print_verdict;
	end
endmodule
